// [gas_alarm_regs.svh]
// Function
// [R1] Concentration above low setpoint enters low alarm, lights low lamp, energises low relay.
// [R2] Concentration above high setpoint enters high alarm, lights high lamp, energises relay.
// [R3] High alarm may only be entered while low alarm is already active; code also enters both together on one sample above both setpoints.
// [R4] Fault relay stays energised while healthy; supply loss reads as fault.
// [R5] Sensor damage, removal or bad calibration enters fault and releases fault relay.
// [R6] Alarms and fault are evaluated independently; detection continues during fault.
// [R7] Automatic mode clears an alarm once concentration falls to half its setpoint.
// [R8] Clearing the fault is ignored while the fault condition persists.
// [R9] Manual mode: operator reset clears an alarm once concentration is below setpoint.
// [R10] Automatic reset after power-up; manual reset selectable by configuration.
// [R11] Both alarm outputs stay blocked during the warm-up period after power-on.
// [R12] After warm-up the status indicator blinks steadily at 1 Hz.
// [R13] In high alarm the low relay stays energised and low lamp lit.
// [R14] Concentration is compared to both setpoints on every valid sample cycle.
`ifndef GAS_ALARM_REGS_SVH
`define GAS_ALARM_REGS_SVH

`define GA_CONC_W         16
`define GA_CLK_HZ         100000000
`define GA_BLINK_HZ       1
`define GA_BLINK_HALF     (`GA_CLK_HZ / (2 * `GA_BLINK_HZ))
`define GA_WARMUP_S       60
`define GA_FAST_HALF      (`GA_CLK_HZ / 16)

`endif

// [gas_alarm_pkg.sv]
package gas_alarm_pkg;
   typedef enum logic [1:0] {
      ST_WARMUP = 2'b00,
      ST_RUN    = 2'b01
   } run_state_t;
endpackage : gas_alarm_pkg

// [gas_alarm_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module gas_alarm_sync (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output var  logic o_level
);
   logic [2:0] sh_ff;
   logic [2:0] nxt_sh;
   logic       lvl_ff;
   logic       nxt_lvl;

   // Shift and agreement filter
   always_comb begin
      nxt_sh  = {sh_ff[1:0], i_async};
      nxt_lvl = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : lvl_ff;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sh_ff  <= 3'h0;
         lvl_ff <= 1'b0;
      end else begin
         sh_ff  <= nxt_sh;
         lvl_ff <= nxt_lvl;
      end
   end

   assign o_level = lvl_ff;
endmodule : gas_alarm_sync
`default_nettype wire

// [gas_alarm_state_controller.sv]
`timescale 1ns/1ns
`default_nettype none
`include "gas_alarm_regs.svh"
module gas_alarm_state_controller #(
   parameter longint unsigned WARMUP_CYCLES = 64'(`GA_WARMUP_S) * 64'(`GA_CLK_HZ),
   parameter int unsigned BLINK_HALF    = `GA_BLINK_HALF,
   parameter int unsigned FAST_HALF     = `GA_FAST_HALF
) (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_n,
   input  wire logic [`GA_CONC_W-1:0] i_conc,
   input  wire logic                  i_conc_valid,
   input  wire logic [`GA_CONC_W-1:0] i_low_setpoint,
   input  wire logic [`GA_CONC_W-1:0] i_high_setpoint,
   input  wire logic                  i_fault_cond,
   input  wire logic                  i_low_manual,
   input  wire logic                  i_high_manual,
   input  wire logic                  i_fault_manual,
   input  wire logic                  i_reset_btn,
   output var  logic                  o_low_alarm_relay,
   output var  logic                  o_high_alarm_relay,
   output var  logic                  o_fault_relay,
   output var  logic                  o_low_alarm_lamp,
   output var  logic                  o_high_alarm_lamp,
   output var  logic                  o_fault_lamp,
   output var  logic                  o_status_led
);
   logic                  rst_s1_ff;
   logic                  rst_s2_ff;
   logic                  rst_n;
   logic                  fault_in;
   logic                  reset_in;
   logic                  reset_prev_ff;
   logic                  nxt_reset_prev;
   logic                  reset_pulse;
   gas_alarm_pkg::run_state_t state_ff;
   gas_alarm_pkg::run_state_t nxt_state;
   logic [63:0]           warm_cnt_ff;   // Wide enough for a full-rate warm-up
   logic [63:0]           nxt_warm_cnt;
   logic                  below_low_ff;  // Last valid sample was under low setpoint
   logic                  nxt_below_low;
   logic                  below_high_ff; // Last valid sample was under high setpoint
   logic                  nxt_below_high;
   logic [31:0]           blink_cnt_ff;
   logic [31:0]           nxt_blink_cnt;
   logic                  led_ff;
   logic                  nxt_led;
   logic                  low_ff;
   logic                  nxt_low;
   logic                  high_ff;
   logic                  nxt_high;
   logic                  fault_ff;
   logic                  nxt_fault;
   logic                  above_low;
   logic                  above_high;
   logic                  below_low;
   logic                  below_high;
   logic                  half_low;
   logic                  half_high;

   // Reset release through two flip-flops
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_n = rst_s2_ff;

   // Pin inputs from outside the clock domain
   gas_alarm_sync u_sync_fault (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (rst_n),
      .i_async   (i_fault_cond),
      .o_level   (fault_in)
   );
   gas_alarm_sync u_sync_reset (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (rst_n),
      .i_async   (i_reset_btn),
      .o_level   (reset_in)
   );

   // Comparisons against setpoints and half setpoints
   always_comb begin
      above_low  = i_conc > i_low_setpoint;
      above_high = i_conc > i_high_setpoint;
      below_low  = i_conc < i_low_setpoint;
      below_high = i_conc < i_high_setpoint;
      half_low   = i_conc <= (i_low_setpoint >> 1);
      half_high  = i_conc <= (i_high_setpoint >> 1);
   end

   // Warm-up and status blink sequencing
   always_comb begin
      nxt_state     = state_ff;
      nxt_warm_cnt  = warm_cnt_ff;
      nxt_blink_cnt = blink_cnt_ff + 32'h0000_0001;
      nxt_led       = led_ff;
      nxt_reset_prev = reset_in;
      unique case (state_ff)
         gas_alarm_pkg::ST_WARMUP: begin
            if (warm_cnt_ff >= WARMUP_CYCLES - 1) begin
               nxt_state     = gas_alarm_pkg::ST_RUN;
               nxt_blink_cnt = 32'h0000_0000;
            end else begin
               nxt_warm_cnt = warm_cnt_ff + 64'h0000_0000_0000_0001;
            end
            if (blink_cnt_ff >= FAST_HALF - 1) begin // Rapid blink while warming
               nxt_blink_cnt = 32'h0000_0000;
               nxt_led       = ~led_ff;
            end
         end
         gas_alarm_pkg::ST_RUN: begin
            if (blink_cnt_ff >= BLINK_HALF - 1) begin // [R12]
               nxt_blink_cnt = 32'h0000_0000;
               nxt_led       = ~led_ff;
            end
         end
         default: nxt_state = gas_alarm_pkg::ST_WARMUP;
      endcase
   end
   assign reset_pulse = reset_in & ~reset_prev_ff;

   // Alarm and fault state; each evaluated independently [R6]
   always_comb begin
      nxt_low   = low_ff;
      nxt_high  = high_ff;
      nxt_fault = fault_ff;
      nxt_below_low  = below_low_ff;
      nxt_below_high = below_high_ff;
      if (i_conc_valid) begin
         nxt_below_low  = below_low;
         nxt_below_high = below_high;
      end
      if (state_ff != gas_alarm_pkg::ST_RUN) begin // [R11]
         nxt_low  = 1'b0;
         nxt_high = 1'b0;
      end else begin
         // Operator command acts on the last sample; a new sample overrides
         if (reset_pulse) begin // [R9]
            if (i_low_manual && low_ff && !high_ff && below_low_ff) nxt_low = 1'b0;
            if (i_high_manual && high_ff && below_high_ff) nxt_high = 1'b0;
         end
         if (i_conc_valid) begin // [R14]
            if (above_low) begin
               nxt_low = 1'b1; // [R1]
            end else if (low_ff && !high_ff) begin
               if (!i_low_manual && half_low) nxt_low = 1'b0; // [R7] [R10]
            end
            if (above_high && (low_ff || above_low)) begin
               nxt_high = 1'b1; // [R2] [R3]
               nxt_low  = 1'b1; // [R13]
            end else if (high_ff) begin
               if (!i_high_manual && half_high) nxt_high = 1'b0; // [R7]
            end
         end
      end
      if (fault_in) begin
         nxt_fault = 1'b1; // [R5]
      end else if (fault_ff) begin
         if (!i_fault_manual || reset_pulse) nxt_fault = 1'b0; // [R8]
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff      <= gas_alarm_pkg::ST_WARMUP;
         warm_cnt_ff   <= 64'h0000_0000_0000_0000;
         below_low_ff  <= 1'b0;
         below_high_ff <= 1'b0;
         blink_cnt_ff  <= 32'h0000_0000;
         led_ff        <= 1'b0;
         low_ff        <= 1'b0;
         high_ff       <= 1'b0;
         fault_ff      <= 1'b0;
         reset_prev_ff <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         warm_cnt_ff   <= nxt_warm_cnt;
         below_low_ff  <= nxt_below_low;
         below_high_ff <= nxt_below_high;
         blink_cnt_ff  <= nxt_blink_cnt;
         led_ff        <= nxt_led;
         low_ff        <= nxt_low;
         high_ff       <= nxt_high;
         fault_ff      <= nxt_fault;
         reset_prev_ff <= nxt_reset_prev;
      end
   end

   // Output drives
   always_comb begin
      o_low_alarm_relay  = low_ff;          // [R1] [R13]
      o_low_alarm_lamp   = low_ff;
      o_high_alarm_relay = high_ff & low_ff; // [R2] [R3]
      o_high_alarm_lamp  = high_ff & low_ff;
      o_fault_relay      = ~fault_ff;       // [R4] [R5]
      o_fault_lamp       = fault_ff;
      o_status_led       = led_ff;
   end
endmodule : gas_alarm_state_controller
`default_nettype wire

// [gas_alarm_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module gas_alarm_chk #(
   parameter longint unsigned WARMUP_CYCLES = 100
) (
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic [15:0] i_conc,
   input wire logic        i_conc_valid,
   input wire logic [15:0] i_low_setpoint,
   input wire logic [15:0] i_high_setpoint,
   input wire logic        i_fault_cond,
   input wire logic        i_low_manual,
   input wire logic        i_high_manual,
   input wire logic        o_low_alarm_relay,
   input wire logic        o_high_alarm_relay,
   input wire logic        o_fault_relay,
   input wire logic        o_low_alarm_lamp,
   input wire logic        o_high_alarm_lamp,
   input wire logic        o_fault_lamp
);
   logic [31:0] age_ff;
   logic [31:0] nxt_age;
   // Cycles since reset release, saturating
   always_comb nxt_age = (&age_ff) ? age_ff : age_ff + 32'h0000_0001;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) age_ff <= 32'h0000_0000;
      else age_ff <= nxt_age;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   property p_warm; age_ff < WARMUP_CYCLES |-> !o_low_alarm_relay && !o_high_alarm_relay; endproperty
   a_warm: assert property (p_warm) else $error("alarm in warm-up");
   property p_lo_set; $rose(o_low_alarm_relay) |-> $past(i_conc_valid && i_conc > i_low_setpoint);
   endproperty
   a_lo_set: assert property (p_lo_set) else $error("low set without cause");
   property p_hi_set; $rose(o_high_alarm_relay) |-> $past(i_conc_valid && i_conc > i_high_setpoint);
   endproperty
   a_hi_set: assert property (p_hi_set) else $error("high set without cause");
   property p_hi_lo; o_high_alarm_relay |-> o_low_alarm_relay && o_low_alarm_lamp; endproperty
   a_hi_lo: assert property (p_hi_lo) else $error("high without low");
   property p_lamps; o_low_alarm_lamp == o_low_alarm_relay && o_high_alarm_lamp == o_high_alarm_relay;
   endproperty
   a_lamps: assert property (p_lamps) else $error("lamp differs from relay");
   property p_fpair; o_fault_relay != o_fault_lamp; endproperty
   a_fpair: assert property (p_fpair) else $error("fault relay and lamp agree");
   property p_fset; $fell(o_fault_relay) |-> $past(i_fault_cond, 2); endproperty
   a_fset: assert property (p_fset) else $error("fault without cause");
   property p_fclr; $fell(o_fault_lamp) |-> !$past(i_fault_cond, 2); endproperty
   a_fclr: assert property (p_fclr) else $error("fault cleared while present");
   property p_lo_clr; $fell(o_low_alarm_relay) && !i_low_manual
      |-> $past(i_conc_valid && i_conc <= (i_low_setpoint >> 1)); endproperty
   a_lo_clr: assert property (p_lo_clr) else $error("low cleared early");
   property p_hi_clr; $fell(o_high_alarm_relay) && !i_high_manual
      |-> $past(i_conc_valid && i_conc <= (i_high_setpoint >> 1)); endproperty
   a_hi_clr: assert property (p_hi_clr) else $error("high cleared early");
endmodule : gas_alarm_chk
`default_nettype wire

// [gas_sensor_model.sv]
`timescale 1ns/1ns
`default_nettype none
module gas_sensor_model (
   input  wire logic        i_clk_sys,
   input  wire logic        i_req,
   input  wire logic [15:0] i_value,
   output var  logic [15:0] o_conc,
   output var  logic        o_valid
);
   // One-cycle sample; line toggles when no sample stands
   always_ff @(posedge i_clk_sys) begin
      o_valid <= i_req;
      o_conc  <= i_req ? i_value : ~o_conc;
   end
endmodule : gas_sensor_model
`default_nettype wire

// [gas_alarm_state_controller_test.sv]
`timescale 1ns/1ns
`default_nettype none
module gas_alarm_state_controller_test;
   localparam logic [15:0] LO = 16'h03e8;
   localparam logic [15:0] HI = 16'h07d0;
   localparam logic [15:0] TV [7] = '{16'h03e9, 16'h07d0, 16'h07d1, 16'h03e9, 16'h03e8, 16'h01f5,
      16'h01f4};
   logic        clk, rst_n, req, fault, lman, hman, fman, btn, valid, l, h, p;
   logic        lr, hr, fr, ll, hl, fl, led;
   logic [15:0] val, conc, c;
   logic [5:0]  outs;
   logic [31:0] seed = 32'h0000_0026;
   int          n_errors = 0, samples_checked = 0, k;
   assign outs = {lr, hr, ll, hl, fr, fl};
   gas_sensor_model u_gas_sensor_model (.i_clk_sys(clk), .i_req(req), .i_value(val),
      .o_conc(conc), .o_valid(valid));
   gas_alarm_state_controller #(.WARMUP_CYCLES(100), .BLINK_HALF(10), .FAST_HALF(3))
      u_gas_alarm_state_controller (.i_clk_sys(clk), .i_rst_n(rst_n), .i_conc(conc),
      .i_conc_valid(valid), .i_low_setpoint(LO), .i_high_setpoint(HI), .i_fault_cond(fault),
      .i_low_manual(lman), .i_high_manual(hman), .i_fault_manual(fman), .i_reset_btn(btn),
      .o_low_alarm_relay(lr), .o_high_alarm_relay(hr), .o_fault_relay(fr),
      .o_low_alarm_lamp(ll), .o_high_alarm_lamp(hl), .o_fault_lamp(fl), .o_status_led(led));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [5:0] ex(input logic el, input logic eh, input logic ef);
      return {el, eh, el, eh, !ef, ef};
   endfunction : ex
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task automatic smp(input logic [15:0] v);
      @(posedge clk);
      req <= 1'h1;
      val <= v;
      @(posedge clk);
      req <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask : smp
   task automatic pin(input logic f, input logic b);
      @(posedge clk);
      fault <= f;
      btn   <= b;
      repeat (8) @(posedge clk);
      btn <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
   endtask : pin
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // Clock and watchdog
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out();
   end
   // Main sequence
   initial begin
      {req, fault, lman, hman, fman, btn, l, h} = '0;
      val   = '0;
      rst_n = 1'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      smp(16'hffff); chk(outs, ex(0, 0, 0));
      repeat (100) @(posedge clk);
      k = 0;
      p = led;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (led !== p) k++;
         p = led;
      end
      chk(6'(k), 6'h04);
      for (int i = 0; i < 7; i++) begin
         smp(TV[i]); chk(outs, ex(7'h3f >> i, 7'h0c >> i, 0));
      end
      for (int i = 0; i < 200; i++) begin
         c = 16'(xs() % 3000);
         if (h && c <= LO / 2) c = LO / 2 + 1;
         h = c > HI || (h && c > HI / 2);
         l = c > LO || h || (l && c > LO / 2);
         smp(c); chk(outs, ex(l, h, 0));
      end
      pin(1'h1, 1'h0); chk(outs, ex(l, h, 1));
      smp(HI + 1); chk(outs, ex(1, 1, 1));
      pin(1'h0, 1'h0); chk(outs, ex(1, 1, 0));
      smp(LO); smp(16'h0000); chk(outs, ex(0, 0, 0));
      fman <= 1'h1;
      lman <= 1'h1;
      hman <= 1'h1;
      pin(1'h1, 1'h1); chk(outs, ex(0, 0, 1));
      pin(1'h0, 1'h0); chk(outs, ex(0, 0, 1));
      pin(1'h0, 1'h1); chk(outs, ex(0, 0, 0));
      smp(LO + 1); pin(1'h0, 1'h1); chk(outs, ex(1, 0, 0));
      smp(LO - 1); chk(outs, ex(1, 0, 0));
      pin(1'h0, 1'h1); chk(outs, ex(0, 0, 0));
      smp(HI + 1); smp(LO); pin(1'h0, 1'h1); chk(outs, ex(1, 0, 0));
      smp(16'h0000); pin(1'h0, 1'h1); chk(outs, ex(0, 0, 0));
      close_out();
   end
endmodule : gas_alarm_state_controller_test
bind gas_alarm_state_controller gas_alarm_chk #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_gas_alarm_chk (
   .i_clk_sys, .i_rst_n, .i_conc, .i_conc_valid, .i_low_setpoint, .i_high_setpoint,
   .i_fault_cond, .i_low_manual, .i_high_manual, .o_low_alarm_relay, .o_high_alarm_relay,
   .o_fault_relay, .o_low_alarm_lamp, .o_high_alarm_lamp, .o_fault_lamp);
`default_nettype wire
